// ==== hdl/irs_map.svh ====
`ifndef IRS_MAP_SVH
`define IRS_MAP_SVH

`define IRS_TARGET_ADDR 7'h5F
`define IRS_ADDR_BYTE_WR 8'hBE
`define IRS_ADDR_BYTE_RD 8'hBF
`define IRS_HS_PREFIX 5'h01
`define IRS_BYTE_BITS 4'h8
`define IRS_LAST_BIT 4'h7
`define IRS_LINE_IDLE 1'b1
`define IRS_CLK_HZ 25000000
`define IRS_SCL_HZ 100000
`define IRS_QTR_CYCLES ((`IRS_CLK_HZ + 4 * `IRS_SCL_HZ - 1) / (4 * `IRS_SCL_HZ))

`endif

// ==== hdl/irs_pkg.sv ====
`default_nettype none

package irs_pkg;

    typedef enum logic [1:0] {
        CMD_START,
        CMD_WRITE,
        CMD_READ,
        CMD_STOP
    } irs_cmd_t;

    typedef enum logic [2:0] {
        TGT_IDLE,
        TGT_RX,
        TGT_ACK,
        TGT_TX,
        TGT_MACK
    } irs_tgt_state_t;

    typedef enum logic [1:0] {
        PH_ADDR,
        PH_PTR,
        PH_DATA
    } irs_phase_t;

    typedef enum logic [1:0] {
        MST_IDLE,
        MST_START,
        MST_BIT,
        MST_STOP
    } irs_mst_state_t;

endpackage

`default_nettype wire

// ==== hdl/irs_bus_if.sv ====
`timescale 1ns/10ps
`default_nettype none

interface irs_bus_if;
    logic sel;
    logic m_scl_o;
    logic m_scl_oe;
    logic m_sda_o;
    logic m_sda_oe;
    logic t_scl_o;
    logic t_scl_oe;
    logic t_sda_o;
    logic t_sda_oe;
    logic scl;
    logic sda;

    // Open-drain wiring with pull-ups: any enabled low driver wins.
    assign scl = !((m_scl_oe && !m_scl_o) || (t_scl_oe && !t_scl_o));
    assign sda = !((m_sda_oe && !m_sda_o) || (t_sda_oe && !t_sda_o));

    modport master (output sel, m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input scl, sda);
    modport target (input sel, scl, sda, output t_scl_o, t_scl_oe, t_sda_o, t_sda_oe);
endinterface // irs_bus_if

`default_nettype wire

// ==== hdl/irs_sync.sv ====
`timescale 1ns/10ps
`default_nettype none

module irs_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clock_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta;

    if (WIDTH < 1) begin : g_chk
        $error("irs_sync needs WIDTH of at least one");
    end

    // The first stage feeds only the second one.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta   <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end
endmodule // irs_sync

`default_nettype wire

// ==== hdl/irs_target.sv ====
// Summary of operation
// - Select pin high enables two-wire access
// - Falling data with clock high opens bus
// - First seven bits address, eighth gives direction
// - Own address 1011111, bytes BEh and BFh
// - Receiver holds data low through acknowledge
// - Receiver acknowledges every complete byte except a foreign address and the last read byte
// - Pointer byte: seven bits register, top increments
// - Increment pointer per data byte when enabled
// - Reads need pointer write then repeated open
// - Writes send data bytes, end with close
// - Master no-ack ends read, target releases
// - Bytes are eight bits, MSB first, unlimited
// - Receiver may hold clock low to stall
// - Unaccepted address leaves acknowledge slot high
// - Rising data with clock high closes, idle
// - Works at standard and fast clock rates
// - Never acknowledge high-speed master code
// - High-speed persists across repeats until close
`timescale 1ns/10ps
`default_nettype none
`include "irs_map.svh"

module irs_target #(
    parameter logic [6:0] OWN_ADDR = `IRS_TARGET_ADDR
) (
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    irs_bus_if.target       bus,
    input  wire logic       stretch_i,
    output logic            wr_en_o,
    output logic [6:0]      wr_addr_o,
    output logic [7:0]      wr_data_o,
    output logic [6:0]      rd_addr_o,
    input  wire logic [7:0] rd_data_i,
    output logic            busy_o,
    output logic            selected_o,
    output logic            hs_mode_o
);
    irs_pkg::irs_tgt_state_t state;
    irs_pkg::irs_tgt_state_t next_state;
    irs_pkg::irs_phase_t     phase;
    irs_pkg::irs_phase_t     next_phase;
    logic [7:0] sh;
    logic [7:0] next_sh;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [6:0] ptr;
    logic [6:0] next_ptr;
    logic       inc;
    logic       next_inc;
    logic       dir_rd;
    logic       next_dir_rd;
    logic       busy;
    logic       next_busy;
    logic       hs;
    logic       next_hs;
    logic       sda_drv;
    logic       next_sda_drv;
    logic       hold;
    logic       next_hold;
    logic       mack_ok;
    logic       next_mack_ok;
    logic       next_wr_en;
    logic [6:0] next_wr_addr;
    logic [7:0] next_wr_data;
    logic       scl_q;
    logic       sda_q;
    logic       sel_s;
    logic       scl_s;
    logic       sda_s;
    logic       scl_rise;
    logic       scl_fall;
    logic       open_cond;
    logic       close_cond;
    logic       addressed;

    // sampling margin
    // Three cycles of lag at 25 MHz stay well inside the 1.3 us low phase of fast mode.
    irs_sync #(
        .WIDTH   (3),
        .RST_VAL (3'h7)
    ) u_sync (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .async_i ({bus.sel, bus.scl, bus.sda}),
        .sync_o  ({sel_s, scl_s, sda_s})
    );

    assign scl_rise   = scl_s && !scl_q;
    assign scl_fall   = !scl_s && scl_q;
    assign open_cond  = scl_s && scl_q && sda_q && !sda_s;
    assign close_cond = scl_s && scl_q && !sda_q && sda_s;
    assign addressed  = (state != irs_pkg::TGT_IDLE) && !(state == irs_pkg::TGT_RX && phase == irs_pkg::PH_ADDR);

    always_comb begin
        next_state   = state;
        next_phase   = phase;
        next_sh      = sh;
        next_cnt     = cnt;
        next_ptr     = ptr;
        next_inc     = inc;
        next_dir_rd  = dir_rd;
        next_busy    = busy;
        next_hs      = hs;
        next_sda_drv = sda_drv;
        next_mack_ok = mack_ok;
        next_wr_en   = 1'b0;
        next_wr_addr = wr_addr_o;
        next_wr_data = wr_data_o;
        next_hold    = stretch_i && addressed && (hold || scl_fall);
        if (!sel_s) begin
            next_state   = irs_pkg::TGT_IDLE;
            next_busy    = 1'b0;
            next_hs      = 1'b0;
            next_sda_drv = 1'b0;
            next_hold    = 1'b0;
        end else if (open_cond) begin
            next_busy    = 1'b1;
            next_state   = irs_pkg::TGT_RX;
            next_phase   = irs_pkg::PH_ADDR;
            next_cnt     = 4'h0;
            next_sda_drv = 1'b0;
        end else if (close_cond) begin
            next_busy    = 1'b0;
            next_hs      = 1'b0;
            next_state   = irs_pkg::TGT_IDLE;
            next_sda_drv = 1'b0;
        end else begin
            unique case (state)
                irs_pkg::TGT_IDLE: begin
                end
                irs_pkg::TGT_RX: begin
                    if (scl_rise) begin
                        next_sh  = {sh[6:0], sda_s};
                        next_cnt = 4'(cnt + 4'h1);
                    end else if (scl_fall && cnt == `IRS_BYTE_BITS) begin
                        next_state   = irs_pkg::TGT_ACK;
                        next_sda_drv = 1'b1;
                        unique case (phase)
                            irs_pkg::PH_ADDR: begin
                                if (sh[7:1] == OWN_ADDR) begin
                                    next_dir_rd = sh[0];
                                end else begin
                                    next_state   = irs_pkg::TGT_IDLE;
                                    next_sda_drv = 1'b0;
                                    if (sh[7:3] == `IRS_HS_PREFIX) begin
                                        next_hs = 1'b1;
                                    end
                                end
                            end
                            irs_pkg::PH_PTR: begin
                                next_ptr = sh[6:0];
                                next_inc = sh[7];
                            end
                            default: begin
                                next_wr_en   = 1'b1;
                                next_wr_addr = ptr;
                                next_wr_data = sh;
                                if (inc) begin
                                    next_ptr = 7'(ptr + 7'h01);
                                end
                            end
                        endcase
                    end
                end
                irs_pkg::TGT_ACK: begin
                    if (scl_fall) begin
                        next_cnt = 4'h0;
                        if (phase == irs_pkg::PH_ADDR && dir_rd) begin
                            next_state   = irs_pkg::TGT_TX;
                            next_sh      = rd_data_i;
                            next_sda_drv = !rd_data_i[7];
                        end else begin
                            next_state   = irs_pkg::TGT_RX;
                            next_sda_drv = 1'b0;
                            next_phase   = (phase == irs_pkg::PH_ADDR) ? irs_pkg::PH_PTR : irs_pkg::PH_DATA;
                        end
                    end
                end
                irs_pkg::TGT_TX: begin
                    if (scl_fall) begin
                        if (cnt == `IRS_LAST_BIT) begin
                            next_state   = irs_pkg::TGT_MACK;
                            next_sda_drv = 1'b0;
                        end else begin
                            next_sh      = {sh[6:0], 1'b0};
                            next_cnt     = 4'(cnt + 4'h1);
                            next_sda_drv = !sh[6];
                        end
                    end
                end
                irs_pkg::TGT_MACK: begin
                    if (scl_rise) begin
                        next_mack_ok = !sda_s;
                        if (inc) begin
                            next_ptr = 7'(ptr + 7'h01);
                        end
                    end else if (scl_fall) begin
                        if (mack_ok) begin
                            next_state   = irs_pkg::TGT_TX;
                            next_cnt     = 4'h0;
                            next_sh      = rd_data_i;
                            next_sda_drv = !rd_data_i[7];
                        end else begin
                            next_state = irs_pkg::TGT_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state     <= irs_pkg::TGT_IDLE;
            phase     <= irs_pkg::PH_ADDR;
            sh        <= 8'h00;
            cnt       <= 4'h0;
            ptr       <= 7'h00;
            inc       <= 1'b0;
            dir_rd    <= 1'b0;
            busy      <= 1'b0;
            hs        <= 1'b0;
            sda_drv   <= 1'b0;
            hold      <= 1'b0;
            mack_ok   <= 1'b0;
            wr_en_o   <= 1'b0;
            wr_addr_o <= 7'h00;
            wr_data_o <= 8'h00;
            scl_q     <= `IRS_LINE_IDLE;
            sda_q     <= `IRS_LINE_IDLE;
        end else begin
            state     <= next_state;
            phase     <= next_phase;
            sh        <= next_sh;
            cnt       <= next_cnt;
            ptr       <= next_ptr;
            inc       <= next_inc;
            dir_rd    <= next_dir_rd;
            busy      <= next_busy;
            hs        <= next_hs;
            sda_drv   <= next_sda_drv;
            hold      <= next_hold;
            mack_ok   <= next_mack_ok;
            wr_en_o   <= next_wr_en;
            wr_addr_o <= next_wr_addr;
            wr_data_o <= next_wr_data;
            scl_q     <= scl_s;
            sda_q     <= sda_s;
        end
    end

    // Pins are open drain: only a low level is ever driven.
    assign bus.t_sda_o  = 1'b0;
    assign bus.t_sda_oe = sda_drv;
    assign bus.t_scl_o  = 1'b0;
    assign bus.t_scl_oe = hold;
    assign rd_addr_o    = ptr;
    assign busy_o       = busy;
    assign selected_o   = addressed;
    assign hs_mode_o    = hs;
endmodule // irs_target

`default_nettype wire

// ==== hdl/irs_master.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "irs_map.svh"

module irs_master #(
    parameter int QTR_CYCLES = `IRS_QTR_CYCLES
) (
    input  wire logic              clock_i,
    input  wire logic              rst_n_i,
    irs_bus_if.master              bus,
    input  wire logic              twowire_en_i,
    input  wire logic              cmd_valid_i,
    input  wire irs_pkg::irs_cmd_t cmd_i,
    input  wire logic [7:0]        wdata_i,
    input  wire logic              last_i,
    output logic                   cmd_ready_o,
    output logic                   done_o,
    output logic [7:0]             rdata_o,
    output logic                   nack_o,
    output logic                   busy_o
);
    irs_pkg::irs_mst_state_t state;
    irs_pkg::irs_mst_state_t next_state;
    logic [7:0] div;
    logic [7:0] next_div;
    logic [1:0] qtr;
    logic [1:0] next_qtr;
    logic [3:0] nbit;
    logic [3:0] next_nbit;
    logic [8:0] txs;
    logic [8:0] next_txs;
    logic [8:0] rxs;
    logic [8:0] next_rxs;
    logic       scl_low;
    logic       next_scl_low;
    logic       sda_low;
    logic       next_sda_low;
    logic       busy;
    logic       next_busy;
    logic       sel;
    logic       next_done;
    logic [7:0] next_rdata;
    logic       next_nack;
    logic       tick;
    logic       scl_s;
    logic       sda_s;

    if (QTR_CYCLES < 2 || QTR_CYCLES > 255) begin : g_chk
        $error("irs_master QTR_CYCLES must lie between 2 and 255");
    end

    irs_sync #(
        .WIDTH   (2),
        .RST_VAL (2'h3)
    ) u_sync (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .async_i ({bus.scl, bus.sda}),
        .sync_o  ({scl_s, sda_s})
    );

    assign tick        = (div == 8'(QTR_CYCLES - 1));
    assign cmd_ready_o = (state == irs_pkg::MST_IDLE) && sel;

    always_comb begin
        next_state   = state;
        next_div     = tick ? 8'h00 : 8'(div + 8'h01);
        next_qtr     = qtr;
        next_nbit    = nbit;
        next_txs     = txs;
        next_rxs     = rxs;
        next_scl_low = scl_low;
        next_sda_low = sda_low;
        next_busy    = busy;
        next_done    = 1'b0;
        next_rdata   = rdata_o;
        next_nack    = nack_o;
        if (!sel) begin
            next_state   = irs_pkg::MST_IDLE;
            next_scl_low = 1'b0;
            next_sda_low = 1'b0;
            next_busy    = 1'b0;
        end else if (state == irs_pkg::MST_IDLE) begin
            if (cmd_valid_i) begin
                next_qtr  = 2'h0;
                next_nbit = 4'h0;
                next_div  = 8'h00;
                unique case (cmd_i)
                    irs_pkg::CMD_START: next_state = irs_pkg::MST_START;
                    irs_pkg::CMD_STOP:  next_state = irs_pkg::MST_STOP;
                    irs_pkg::CMD_WRITE: begin
                        next_state = irs_pkg::MST_BIT;
                        next_txs   = {wdata_i, 1'b1};
                    end
                    irs_pkg::CMD_READ: begin
                        next_state = irs_pkg::MST_BIT;
                        next_txs   = {8'hFF, last_i};
                    end
                endcase
            end
        end else if (tick) begin
            next_qtr = 2'(qtr + 2'h1);
            unique case (qtr)
                2'h0: begin
                    if (state == irs_pkg::MST_START) begin
                        next_sda_low = 1'b0;
                    end else if (state == irs_pkg::MST_STOP) begin
                        next_sda_low = 1'b1;
                    end else begin
                        next_sda_low = !txs[8];
                    end
                end
                2'h1: next_scl_low = 1'b0;
                2'h2: begin
                    if (!scl_s) begin
                        next_qtr = qtr;
                    end else if (state == irs_pkg::MST_START) begin
                        next_sda_low = 1'b1;
                    end else if (state == irs_pkg::MST_BIT) begin
                        next_rxs = {rxs[7:0], sda_s};
                    end
                end
                default: begin
                    next_qtr = 2'h0;
                    if (state == irs_pkg::MST_STOP) begin
                        next_sda_low = 1'b0;
                        next_busy    = 1'b0;
                        next_done    = 1'b1;
                        next_state   = irs_pkg::MST_IDLE;
                    end else begin
                        next_scl_low = 1'b1;
                        if (state == irs_pkg::MST_START) begin
                            next_busy  = 1'b1;
                            next_done  = 1'b1;
                            next_state = irs_pkg::MST_IDLE;
                        end else begin
                            next_txs  = {txs[7:0], 1'b1};
                            next_nbit = 4'(nbit + 4'h1);
                            if (nbit == `IRS_BYTE_BITS) begin
                                next_rdata = rxs[8:1];
                                next_nack  = rxs[0];
                                next_done  = 1'b1;
                                next_state = irs_pkg::MST_IDLE;
                            end
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state   <= irs_pkg::MST_IDLE;
            div     <= 8'h00;
            qtr     <= 2'h0;
            nbit    <= 4'h0;
            txs     <= 9'h1FF;
            rxs     <= 9'h000;
            scl_low <= 1'b0;
            sda_low <= 1'b0;
            busy    <= 1'b0;
            sel     <= 1'b0;
            done_o  <= 1'b0;
            rdata_o <= 8'h00;
            nack_o  <= 1'b0;
        end else begin
            state   <= next_state;
            div     <= next_div;
            qtr     <= next_qtr;
            nbit    <= next_nbit;
            txs     <= next_txs;
            rxs     <= next_rxs;
            scl_low <= next_scl_low;
            sda_low <= next_sda_low;
            busy    <= next_busy;
            sel     <= twowire_en_i;
            done_o  <= next_done;
            rdata_o <= next_rdata;
            nack_o  <= next_nack;
        end
    end

    assign bus.sel      = sel;
    assign bus.m_scl_o  = 1'b0;
    assign bus.m_scl_oe = scl_low;
    assign bus.m_sda_o  = 1'b0;
    assign bus.m_sda_oe = sda_low;
    assign busy_o       = busy;
endmodule // irs_master

`default_nettype wire

// ==== tb/irs_bus_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module irs_bus_assertions (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic sel,
    input wire logic m_sda_oe,
    input wire logic t_scl_oe,
    input wire logic t_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // The select pin reaches the target through sync stages, so waits allow for that lag.
    AST_SEL_RELEASE: assert property ((!sel)[*4] |-> !t_sda_oe && !t_scl_oe)
        else $error("target drives pins while deselected");
    AST_ACK_HOLD: assert property (sel && $past(sel, 4) && scl && $past(scl) |-> $stable(t_sda_oe))
        else $error("target data changed during clock high");
    AST_NO_FIGHT: assert property (scl |-> !(t_sda_oe && m_sda_oe))
        else $error("both ends drive data during clock high");
    AST_STRETCH_LOW: assert property ($rose(t_scl_oe) |-> !$past(scl))
        else $error("target pulled clock while it was high");
    AST_OPEN_QUIET: assert property ($fell(sda) && scl && $past(scl) |=> (!t_sda_oe)[*8])
        else $error("target drives data right after open condition");
    AST_CLOSE_IDLE: assert property ($rose(sda) && scl && $past(scl) |=> (!t_sda_oe && !t_scl_oe)[*8])
        else $error("target not idle after close condition");
    AST_SCL_HIGH_TIME: assert property ($rose(scl) |-> scl[*4])
        else $error("clock high phase too short");
    AST_EDGE_WHILE_LOW: assert property (($rose(t_sda_oe) || $fell(t_sda_oe)) && sel |-> !scl && !$past(scl))
        else $error("target data edge while clock high");
    COV_STRETCH: cover property ($rose(t_scl_oe));
    COV_TARGET_DRIVE: cover property ($rose(t_sda_oe));
    COV_CLOSE: cover property ($rose(sda) && scl && $past(scl));
endmodule // irs_bus_assertions
`default_nettype wire

// ==== tb/i2c_register_slave_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module i2c_register_slave_tb_top;
    logic              clock_i = 1'b0;
    logic              rst_n_i = 1'b0;
    logic              twowire_en_i = 1'b1;
    logic              cmd_valid_i = 1'b0;
    irs_pkg::irs_cmd_t cmd_i = irs_pkg::CMD_STOP;
    logic [7:0]        wdata_i = 8'h00;
    logic              last_i = 1'b0;
    logic              stretch_i = 1'b0;
    logic              sfl = 1'b0;
    logic              cmd_ready_o, done_o, nack_o, m_busy, wr_en_o, t_busy, selected_o, hs_mode_o;
    logic [7:0]        rdata_o, wr_data_o, rd_data_i;
    logic [6:0]        wr_addr_o, rd_addr_o;
    logic [6:0]        wq_a[$];
    logic [7:0]        wq_d[$];
    int                mismatches = 0;
    int                n_tests = 0;
    integer            seed = 27158;
    irs_bus_if bus ();
    irs_master #(.QTR_CYCLES(4)) irs_master_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .bus(bus),
        .twowire_en_i(twowire_en_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .wdata_i(wdata_i), .last_i(last_i),
        .cmd_ready_o(cmd_ready_o), .done_o(done_o), .rdata_o(rdata_o), .nack_o(nack_o), .busy_o(m_busy));
    irs_target irs_target_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .bus(bus), .stretch_i(stretch_i),
        .wr_en_o(wr_en_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .rd_addr_o(rd_addr_o),
        .rd_data_i(rd_data_i), .busy_o(t_busy), .selected_o(selected_o), .hs_mode_o(hs_mode_o));
    irs_bus_assertions irs_bus_assertions_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .sel(bus.sel),
        .m_sda_oe(bus.m_sda_oe), .t_scl_oe(bus.t_scl_oe), .t_sda_oe(bus.t_sda_oe), .scl(bus.scl), .sda(bus.sda));

    // Register contents are a fixed pattern of the address, so reads need no stored state.
    function automatic logic [7:0] regv(input logic [6:0] a);
        return {a, 1'b0} ^ 8'hA5;
    endfunction
    assign rd_data_i = regv(rd_addr_o);

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic stop_test();
        $display("mismatches %0d n_tests %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic cmd(input irs_pkg::irs_cmd_t c, input logic [7:0] d, input logic l);
        int k;
        k = 0;
        while (cmd_ready_o !== 1'b1 && k < 2000) begin
            @(negedge clock_i);
            k++;
        end
        @(posedge clock_i);
        cmd_valid_i <= 1'b1;
        cmd_i <= c;
        wdata_i <= d;
        last_i <= l;
        @(posedge clock_i);
        cmd_valid_i <= 1'b0;
        k = 0;
        do begin
            @(negedge clock_i);
            k++;
        end while (done_o !== 1'b1 && k < 5000);
        chk("done", 8'h01, {7'h00, done_o});
        // The target sees the close condition only after its synchronisers, a few cycles later.
        if (c == irs_pkg::CMD_STOP) repeat (4) @(negedge clock_i);
    endtask

    task automatic xfer(input logic rd, input logic [7:0] p, input int n);
        logic [7:0] d;
        cmd(irs_pkg::CMD_START, 8'h00, 1'b0);
        chk("t_busy", 8'h01, {7'h00, t_busy});
        chk("m_busy", 8'h01, {7'h00, m_busy});
        cmd(irs_pkg::CMD_WRITE, 8'hBE, 1'b0);
        chk("addr_nack", 8'h00, {7'h00, nack_o});
        chk("selected", 8'h01, {7'h00, selected_o});
        cmd(irs_pkg::CMD_WRITE, p, 1'b0);
        chk("ptr_nack", 8'h00, {7'h00, nack_o});
        if (rd) begin
            cmd(irs_pkg::CMD_START, 8'h00, 1'b0);
            cmd(irs_pkg::CMD_WRITE, 8'hBF, 1'b0);
            chk("rd_addr_nack", 8'h00, {7'h00, nack_o});
        end
        for (int i = 0; i < n; i++) begin
            d = $random(seed);
            if (!rd) begin
                wq_a.push_back(7'(p[6:0] + (p[7] ? i : 0)));
                wq_d.push_back(d);
            end
            cmd(rd ? irs_pkg::CMD_READ : irs_pkg::CMD_WRITE, d, i == n - 1);
            if (rd) chk("rdata", regv(7'(p[6:0] + (p[7] ? i : 0))), rdata_o);
            else chk("data_nack", 8'h00, {7'h00, nack_o});
        end
        cmd(irs_pkg::CMD_STOP, 8'h00, 1'b0);
        chk("t_idle", 8'h00, {7'h00, t_busy});
        chk("m_idle", 8'h00, {7'h00, m_busy});
    endtask

    always @(negedge clock_i) begin
        if (wr_en_o === 1'b1) begin
            chk("wr_pending", 8'h01, {7'h00, wq_a.size() > 0});
            if (wq_a.size() > 0) begin
                chk("wr_addr", {1'b0, wq_a.pop_front()}, {1'b0, wr_addr_o});
                chk("wr_data", wq_d.pop_front(), wr_data_o);
            end
        end
    end

    // Random short stalls are kept brief so a stretched byte never outlasts the wait bound.
    always @(posedge clock_i) stretch_i <= sfl && ($random(seed) % 3 == 0);

    initial begin
        forever #20 clock_i = ~clock_i;
    end

    initial begin
        repeat (80000) @(posedge clock_i);
        mismatches++;
        stop_test();
    end

    initial begin
        logic [7:0] a;
        repeat (3) @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (6) @(negedge clock_i);
        xfer(1'b0, 8'hFE, 3);
        xfer(1'b1, 8'hFE, 3);
        for (int it = 0; it < 10; it++) begin
            sfl = it[0];
            xfer(it[1], 8'($random(seed)), 1 + $unsigned($random(seed)) % 4);
        end
        sfl = 1'b0;
        a = $random(seed);
        a = a ^ ((a[7:1] == 7'h5F) ? 8'h04 : 8'h00);
        cmd(irs_pkg::CMD_START, 8'h00, 1'b0);
        cmd(irs_pkg::CMD_WRITE, a, 1'b0);
        chk("foreign_nack", 8'h01, {7'h00, nack_o});
        cmd(irs_pkg::CMD_STOP, 8'h00, 1'b0);
        for (int j = 0; j < 8; j++) begin
            cmd(irs_pkg::CMD_START, 8'h00, 1'b0);
            cmd(irs_pkg::CMD_WRITE, {5'h01, 3'(j)}, 1'b0);
            chk("code_nack", 8'h01, {7'h00, nack_o});
            cmd(irs_pkg::CMD_START, 8'h00, 1'b0);
            cmd(irs_pkg::CMD_WRITE, 8'hBE, 1'b0);
            chk("hs_kept", 8'h01, {7'h00, hs_mode_o});
            cmd(irs_pkg::CMD_STOP, 8'h00, 1'b0);
            chk("hs_cleared", 8'h00, {7'h00, hs_mode_o});
        end
        cmd(irs_pkg::CMD_START, 8'h00, 1'b0);
        cmd(irs_pkg::CMD_WRITE, 8'hBE, 1'b0);
        @(posedge clock_i);
        twowire_en_i <= 1'b0;
        repeat (8) @(negedge clock_i);
        chk("ready_off", 8'h00, {7'h00, cmd_ready_o});
        chk("deselect", 8'h00, {6'h00, t_busy, selected_o});
        @(posedge clock_i);
        twowire_en_i <= 1'b1;
        repeat (4) @(negedge clock_i);
        cmd(irs_pkg::CMD_STOP, 8'h00, 1'b0);
        xfer(1'b0, 8'h05, 2);
        chk("wr_left", 8'h00, 8'(wq_a.size()));
        stop_test();
    end
endmodule // i2c_register_slave_tb_top
`default_nettype wire
